// [mims_defs.svh]
/*
 * Register offsets, field positions, reset values and fixed figures of the
 * matrix multiply-subtract / outer-product datapath.
 * Assumes it is included by its bare name, before any module that uses it.
 */
// Operation
// - size bit picks 32 or 64-bit accumulators
// - 64-bit form undefined without wide option
// - both instructions undefined without version two
// - select field names general registers W8-W11
// - offset is field times four, four vectors
// - multi form: first source base is field times group count
// - multi form: second source base plus group
// - single form: first source wraps, second Z0-Z15
// - start vector: sum mod stride, multiple of four
// - lanes pair source element 4e+i; stride advances
// - truncated product subtracted, written back
// - multiply-subtract ignores predicates entirely
// - qualifier means two or four groups
// - outer product: 32-bit tile, 16-bit sources
// - inactive source element contributes zero
// - tile element adds widened two-way dot product
// - each source container holds two elements
// - destination tile field selects tiles 0-3
// - predicate fields select P0 through P7
// - predicate length VL/8, tile dimension VL/32
`ifndef MIMS_DEFS_SVH
`define MIMS_DEFS_SVH

`define MIMS_CMD       8'h00
`define MIMS_CFG       8'h04
`define MIMS_STAT      8'h08
`define MIMS_SEL       8'h0C
`define MIMS_DATA      8'h10

`define MIMS_CMD_START 0
`define MIMS_CMD_OP    1
`define MIMS_CMD_ES    2
`define MIMS_CMD_FOUR  3
`define MIMS_CMD_MULTI 4
`define MIMS_CMD_VR    5
`define MIMS_CMD_OFS   7
`define MIMS_CMD_SA    8
`define MIMS_CMD_SB    13
`define MIMS_CMD_DA    18
`define MIMS_CMD_GA    20
`define MIMS_CMD_GB    23

`define MIMS_CFG_V2    0
`define MIMS_CFG_WIDE  1
`define MIMS_CFG_SM    2
`define MIMS_CFG_MA    3
`define MIMS_CFG_RST   32'h0000_000F

`define MIMS_ST_BUSY   0
`define MIMS_ST_DONE   1
`define MIMS_ST_UNDEF  2
`define MIMS_ST_TRAP   3

`define MIMS_SEL_SPACE 0
`define MIMS_SEL_ENTRY 4
`define MIMS_SEL_WORD  12

`define MIMS_VR_PREFIX 3'h2
`define MIMS_ACC_BASE  32

`endif

// [mims_pkg.sv]
/*
 * Types shared by the datapath top and its vector lane unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mims_pkg;

	typedef enum logic [1:0] {
		MIMS_OKAY   = 2'b00,
		MIMS_SLVERR = 2'b10
	} mims_resp_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CHECK = 3'b001,
		ST_MSUB  = 3'b010,
		ST_OPA   = 3'b011
	} mims_state_t;

	typedef enum logic [1:0] {
		SP_VEC  = 2'b00,
		SP_PRED = 2'b01,
		SP_GEN  = 2'b10,
		SP_ARR  = 2'b11
	} mims_space_t;

endpackage : mims_pkg

// [mims_lane_if.sv]
/*
 * Operands and result of one matrix-array vector update.
 * Assumes the top drives the operands and the lane unit drives the result.
 */
`timescale 1ns/1ps
interface mims_lane_if #(
	parameter int VL = 128
);
	logic [VL-1:0] op1;
	logic [VL-1:0] op2;
	logic [VL-1:0] acc;
	logic [1:0]    sel;
	logic          wide;
	logic [VL-1:0] result;

	modport top  (output op1, output op2, output acc, output sel, output wide, input result);
	modport unit (input op1, input op2, input acc, input sel, input wide, output result);
endinterface : mims_lane_if

// [mims_msub_lane.sv]
/*
 * Combinational multiply-subtract across one vector: each accumulator element
 * loses the truncated product of narrow source elements 4e+sel.
 * Assumes VL is a multiple of 64.
 */
`timescale 1ns/1ps
module mims_msub_lane #(
	parameter int VL = 128
) (
	mims_lane_if.unit ln
);
	import mims_pkg::*;

	logic [VL-1:0] res32;
	logic [VL-1:0] res64;

	// a signed narrow product already fits the accumulator, so truncation is
	// just sign extension
	for (genvar e = 0; e < VL / 32; e++) begin : g_s
		logic signed [7:0]  a;
		logic signed [7:0]  b;
		logic signed [15:0] p;
		assign a = ln.op1[32*e + 8*ln.sel +: 8];
		assign b = ln.op2[32*e + 8*ln.sel +: 8];
		assign p = a * b;
		assign res32[32*e +: 32] = ln.acc[32*e +: 32] - {{16{p[15]}}, p};
	end

	for (genvar e = 0; e < VL / 64; e++) begin : g_d
		logic signed [15:0] a;
		logic signed [15:0] b;
		logic signed [31:0] p;
		assign a = ln.op1[64*e + 16*ln.sel +: 16];
		assign b = ln.op2[64*e + 16*ln.sel +: 16];
		assign p = a * b;
		assign res64[64*e +: 64] = ln.acc[64*e +: 64] - {{32{p[31]}}, p};
	end

	// accumulator width is 32 << size bit
	assign ln.result = ln.wide ? res64 : res32;

endmodule : mims_msub_lane

// [mims_top.sv]
/*
 * Matrix integer datapath: widening multiply-subtract into quad-vector groups
 * of the matrix array, and 2-way signed outer-product accumulate into a
 * 32-bit tile. Vector, predicate, general and array state live here and are
 * reached, like control and status, over an AXI4-Lite slave.
 * Assumes VL is a power of two, 128 to 256, and a single clock domain.
 */
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "mims_defs.svh"
module mims_top #(
	parameter int VL = 128
) (
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	input  wire logic [31:0]        s_axi_awaddr_i,
	input  wire logic               s_axi_awvalid_i,
	output logic                    s_axi_awready_o,
	input  wire logic [31:0]        s_axi_wdata_i,
	input  wire logic [3:0]         s_axi_wstrb_i,
	input  wire logic               s_axi_wvalid_i,
	output logic                    s_axi_wready_o,
	output mims_pkg::mims_resp_t    s_axi_bresp_o,
	output logic                    s_axi_bvalid_o,
	input  wire logic               s_axi_bready_i,
	input  wire logic [31:0]        s_axi_araddr_i,
	input  wire logic               s_axi_arvalid_i,
	output logic                    s_axi_arready_o,
	output logic [31:0]             s_axi_rdata_o,
	output mims_pkg::mims_resp_t    s_axi_rresp_o,
	output logic                    s_axi_rvalid_o,
	input  wire logic               s_axi_rready_i
);
	import mims_pkg::*;

	localparam int NVEC = VL / 8;           // matrix array vectors
	localparam int PL   = VL / 8;           // predicate bits
	localparam int DIM  = VL / 32;          // 32-bit tile dimension
	localparam int ZAW  = $clog2(NVEC);
	localparam int RB   = $clog2(DIM);
	localparam int WW   = $clog2(VL / 32);

	logic rst_q1;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	// architectural state
	logic [VL-1:0]  z_regs [32];
	logic [PL-1:0]  p_regs [8];
	logic [31:0]    w_regs [8:11];
	logic [VL-1:0]  ma     [NVEC];

	logic [31:0]    cmd_q;
	logic [31:0]    cfg_q;
	logic [31:0]    sel_q;
	logic           done_q;
	logic           undef_q;
	logic           trap_q;
	mims_state_t    state;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// write channel
	logic        aw_got;
	logic        w_got;
	logic [7:0]  aw_addr_q;
	logic        aw_high_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_fire;
	logic        wr_map;

	assign wr_fire = aw_got && w_got && !s_axi_bvalid_o;
	assign wr_map  = !aw_high_q && (aw_addr_q == `MIMS_CMD || aw_addr_q == `MIMS_CFG ||
		aw_addr_q == `MIMS_STAT || aw_addr_q == `MIMS_SEL || aw_addr_q == `MIMS_DATA);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= MIMS_OKAY;
			aw_got          <= 1'b0;
			w_got           <= 1'b0;
			aw_addr_q       <= 8'h00;
			aw_high_q       <= 1'b0;
			w_data_q        <= 32'h0000_0000;
			w_strb_q        <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_addr_q       <= s_axi_awaddr_i[7:0];
				aw_high_q       <= |s_axi_awaddr_i[31:8];
				aw_got          <= 1'b1;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data_q       <= s_axi_wdata_i;
				w_strb_q       <= s_axi_wstrb_i;
				w_got          <= 1'b1;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_map ? MIMS_OKAY : MIMS_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				aw_got          <= 1'b0;
				w_got           <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	logic              busy;
	logic              go;
	logic              win_wr;
	mims_space_t       sel_space;
	logic [4:0]        sel_entry;
	logic [WW-1:0]     sel_word;

	assign busy      = (state != ST_IDLE);
	assign go        = wr_fire && !aw_high_q && aw_addr_q == `MIMS_CMD && w_strb_q[0] &&
		w_data_q[`MIMS_CMD_START] && !busy;
	// operand state is frozen while an instruction runs; such writes are dropped
	assign win_wr    = wr_fire && !aw_high_q && aw_addr_q == `MIMS_DATA && !busy;
	assign sel_space = mims_space_t'(sel_q[`MIMS_SEL_SPACE +: 2]);
	assign sel_entry = sel_q[`MIMS_SEL_ENTRY +: 5];
	assign sel_word  = sel_q[`MIMS_SEL_WORD +: WW];

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= 32'h0000_0000;
			cfg_q <= `MIMS_CFG_RST;
			sel_q <= 32'h0000_0000;
		end else if (wr_fire && !aw_high_q) begin
			if (aw_addr_q == `MIMS_CMD && !busy) begin
				cmd_q <= merge(cmd_q, w_data_q, w_strb_q) & ~(32'h1 << `MIMS_CMD_START);
			end
			if (aw_addr_q == `MIMS_CFG && !busy) begin
				cfg_q <= merge(cfg_q, w_data_q, w_strb_q) & 32'h0000_000F;
			end
			if (aw_addr_q == `MIMS_SEL) begin
				sel_q <= merge(sel_q, w_data_q, w_strb_q);
			end
		end
	end

	// vector, predicate and general registers: software writes only
	always_ff @(posedge clk_i) begin
		if (win_wr) begin
			case (sel_space)
				SP_VEC: begin
					z_regs[sel_entry][32*sel_word +: 32] <=
						merge(z_regs[sel_entry][32*sel_word +: 32], w_data_q, w_strb_q);
				end
				SP_PRED: begin
					p_regs[sel_entry[2:0]] <=
						PL'(merge(32'(p_regs[sel_entry[2:0]]), w_data_q, w_strb_q));
				end
				SP_GEN: begin
					w_regs[{`MIMS_VR_PREFIX, sel_entry[1:0]}] <=
						merge(w_regs[{`MIMS_VR_PREFIX, sel_entry[1:0]}], w_data_q, w_strb_q);
				end
				default: begin
				end
			endcase
		end
	end

	// latched instruction fields
	logic           op_opa;
	logic           es;
	logic           four;
	logic           multi;
	logic [1:0]     vr;
	logic           ofs;
	logic [4:0]     sa;
	logic [4:0]     sb;
	logic [1:0]     da;
	logic [2:0]     ga;
	logic [2:0]     gb;

	assign op_opa = cmd_q[`MIMS_CMD_OP];
	assign es     = cmd_q[`MIMS_CMD_ES];
	assign four   = cmd_q[`MIMS_CMD_FOUR];
	assign multi  = cmd_q[`MIMS_CMD_MULTI];
	assign vr     = cmd_q[`MIMS_CMD_VR +: 2];
	assign ofs    = cmd_q[`MIMS_CMD_OFS];
	assign sa     = cmd_q[`MIMS_CMD_SA +: 5];
	assign sb     = cmd_q[`MIMS_CMD_SB +: 5];
	assign da     = cmd_q[`MIMS_CMD_DA +: 2];
	assign ga     = cmd_q[`MIMS_CMD_GA +: 3];
	assign gb     = cmd_q[`MIMS_CMD_GB +: 3];

	// sequencing
	logic [1:0]     r_cnt;
	logic [1:0]     i_cnt;
	logic [RB-1:0]  row;
	logic [ZAW-1:0] vec_cur;
	logic [ZAW-1:0] stride;
	logic [ZAW-1:0] vec_start;
	logic [31:0]    vsum;
	logic [1:0]     last_r;
	logic           is_undef;
	logic           is_trap;

	assign stride = four ? ZAW'(NVEC / 4) : ZAW'(NVEC / 2);
	assign last_r = four ? 2'h3 : 2'h1;
	assign vsum   = w_regs[{`MIMS_VR_PREFIX, vr}] + {29'h0, ofs, 2'h0};
	assign vec_start = vsum[ZAW-1:0] & (stride - ZAW'(1)) & ~ZAW'(3);
	assign is_undef = !cfg_q[`MIMS_CFG_V2] ||
		(!op_opa && es && !cfg_q[`MIMS_CFG_WIDE]);
	assign is_trap  = !(cfg_q[`MIMS_CFG_SM] && cfg_q[`MIMS_CFG_MA]);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state   <= ST_IDLE;
			r_cnt   <= 2'h0;
			i_cnt   <= 2'h0;
			row     <= '0;
			vec_cur <= '0;
			done_q  <= 1'b0;
			undef_q <= 1'b0;
			trap_q  <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (go) begin
						state   <= ST_CHECK;
						done_q  <= 1'b0;
						undef_q <= 1'b0;
						trap_q  <= 1'b0;
					end
				end
				ST_CHECK: begin
					r_cnt   <= 2'h0;
					i_cnt   <= 2'h0;
					row     <= '0;
					vec_cur <= vec_start;
					// decode faults outrank the enable check
					if (is_undef) begin
						undef_q <= 1'b1;
						done_q  <= 1'b1;
						state   <= ST_IDLE;
					end else if (is_trap) begin
						trap_q <= 1'b1;
						done_q <= 1'b1;
						state  <= ST_IDLE;
					end else begin
						state <= op_opa ? ST_OPA : ST_MSUB;
					end
				end
				ST_MSUB: begin
					i_cnt <= i_cnt + 2'h1;
					if (i_cnt == 2'h3) begin
						vec_cur <= vec_cur + stride;
						r_cnt   <= r_cnt + 2'h1;
						if (r_cnt == last_r) begin
							done_q <= 1'b1;
							state  <= ST_IDLE;
						end
					end
				end
				ST_OPA: begin
					row <= row + RB'(1);
					if (row == RB'(DIM - 1)) begin
						done_q <= 1'b1;
						state  <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// multiply-subtract operand selection
	logic [4:0]     n_base;
	logic [4:0]     m_base;
	logic [4:0]     n_idx;
	logic [4:0]     m_idx;
	logic [ZAW-1:0] ms_row;

	assign n_base = !multi ? sa : (four ? {sa[2:0], 2'h0} : {sa[3:0], 1'h0});
	assign m_base = !multi ? {1'b0, sb[3:0]} :
		(four ? {sb[2:0], 2'h0} : {sb[3:0], 1'h0});
	assign n_idx  = n_base + {3'h0, r_cnt};
	assign m_idx  = multi ? m_base + {3'h0, r_cnt} : m_base;
	assign ms_row = vec_cur + ZAW'(i_cnt);

	mims_lane_if #(.VL(VL)) lane ();

	// no predicate enters the multiply-subtract path
	assign lane.op1  = z_regs[n_idx];
	assign lane.op2  = z_regs[m_idx];
	assign lane.acc  = ma[ms_row];
	assign lane.sel  = i_cnt;
	assign lane.wide = es;

	mims_msub_lane #(.VL(VL)) u_lane (
		.ln (lane)
	);

	// outer product: tile row `row` of tile da is array vector 4*row+da
	logic [ZAW-1:0]    opa_row;
	logic [VL-1:0]     opa_res;
	logic [VL-1:0]     opa_acc;
	logic [PL-1:0]     mask1;
	logic [PL-1:0]     mask2;
	logic signed [15:0] a0;
	logic signed [15:0] a1;

	assign opa_row = {row, da};
	assign opa_acc = ma[opa_row];
	assign mask1   = p_regs[ga];
	assign mask2   = p_regs[gb];
	// a 16-bit element j is governed by predicate bit 2*j
	assign a0 = mask1[4*row]     ? z_regs[sa][32*row +: 16]      : 16'sh0000;
	assign a1 = mask1[4*row + 2] ? z_regs[sa][32*row + 16 +: 16] : 16'sh0000;

	for (genvar c = 0; c < DIM; c++) begin : g_col
		logic signed [15:0] b0;
		logic signed [15:0] b1;
		logic signed [31:0] p0;
		logic signed [31:0] p1;
		assign b0 = mask2[4*c]     ? z_regs[sb][32*c +: 16]      : 16'sh0000;
		assign b1 = mask2[4*c + 2] ? z_regs[sb][32*c + 16 +: 16] : 16'sh0000;
		assign p0 = a0 * b0;
		assign p1 = a1 * b1;
		assign opa_res[32*c +: 32] = opa_acc[32*c +: 32] + p0 + p1;
	end

	// matrix array: software window and both instruction write-backs
	always_ff @(posedge clk_i) begin
		if (state == ST_MSUB) begin
			ma[ms_row] <= lane.result;
		end else if (state == ST_OPA) begin
			ma[opa_row] <= opa_res;
		end else if (win_wr && sel_space == SP_ARR) begin
			ma[sel_entry[ZAW-1:0]][32*sel_word +: 32] <=
				merge(ma[sel_entry[ZAW-1:0]][32*sel_word +: 32], w_data_q, w_strb_q);
		end
	end

	// read channel
	logic [31:0] rd_mux;
	logic        rd_map;

	always_comb begin
		rd_map = 1'b1;
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr_i[7:0])
			`MIMS_CMD:  rd_mux = cmd_q;
			`MIMS_CFG:  rd_mux = cfg_q;
			`MIMS_STAT: rd_mux = {28'h0, trap_q, undef_q, done_q, busy};
			`MIMS_SEL:  rd_mux = sel_q;
			`MIMS_DATA: begin
				case (sel_space)
					SP_VEC:  rd_mux = z_regs[sel_entry][32*sel_word +: 32];
					SP_PRED: rd_mux = 32'(p_regs[sel_entry[2:0]]);
					SP_GEN:  rd_mux = w_regs[{`MIMS_VR_PREFIX, sel_entry[1:0]}];
					default: rd_mux = ma[sel_entry[ZAW-1:0]][32*sel_word +: 32];
				endcase
			end
			default: rd_map = 1'b0;
		endcase
		if (|s_axi_araddr_i[31:8]) begin
			rd_map = 1'b0;
			rd_mux = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= MIMS_OKAY;
		end else begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rdata_o   <= rd_mux;
				s_axi_rresp_o   <= rd_map ? MIMS_OKAY : MIMS_SLVERR;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o  <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

endmodule : mims_top

// [mims_properties.sv]
/* Handshake checks on the register bus ports of the datapath top.
   Assumes it is bound to mims_top and one clock domain. */
`timescale 1ns/1ps
module mims_properties #(
	parameter int VL = 128
) (
	input wire logic                 clk_i,
	input wire logic                 rst_n_i,
	input wire logic [31:0]          s_axi_awaddr_i,
	input wire logic                 s_axi_awvalid_i,
	input wire logic                 s_axi_awready_o,
	input wire logic                 s_axi_wvalid_i,
	input wire logic                 s_axi_wready_o,
	input wire mims_pkg::mims_resp_t s_axi_bresp_o,
	input wire logic                 s_axi_bvalid_o,
	input wire logic                 s_axi_bready_i,
	input wire logic                 s_axi_arvalid_i,
	input wire logic                 s_axi_arready_o,
	input wire logic [31:0]          s_axi_rdata_o,
	input wire logic                 s_axi_rvalid_o,
	input wire logic                 s_axi_rready_i
);
	import mims_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wr_take;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_bad_addr;
		s_wr_take ##0 (s_axi_awaddr_i[31:8] != 24'h0);
	endsequence
	property p_b_after;
		s_wr_take |=> ##1 s_axi_bvalid_o;
	endproperty
	property p_slverr;
		s_bad_addr |=> ##1 s_axi_bvalid_o && s_axi_bresp_o == MIMS_SLVERR;
	endproperty
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	property p_b_block;
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
	endproperty
	property p_b_free;
		s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o;
	endproperty
	property p_r_after;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
	endproperty
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	property p_r_free;
		s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write response late");
	a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	a_b_block: assert property (p_b_block) else $error("write taken while answering");
	a_b_free: assert property (p_b_free) else $error("write channel not freed");
	a_r_after: assert property (p_r_after) else $error("read answer late");
	a_r_hold: assert property (p_r_hold) else $error("read answer changed");
	a_r_free: assert property (p_r_free) else $error("read answer repeated");
endmodule : mims_properties

bind mims_top mims_properties #(.VL(VL)) u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i));

// [mims_host.sv]
/* Register bus master standing in for the core that issues the instructions.
   Assumes tasks are called from one process, never two at once. */
`timescale 1ns/1ps
module mims_host (
	input  wire logic                 clk_i,
	output logic [31:0]               awaddr_o,
	output logic                      awvalid_o,
	input  wire logic                 awready_i,
	output logic [31:0]               wdata_o,
	output logic [3:0]                wstrb_o,
	output logic                      wvalid_o,
	input  wire logic                 wready_i,
	input  wire mims_pkg::mims_resp_t bresp_i,
	input  wire logic                 bvalid_i,
	output logic                      bready_o,
	output logic [31:0]               araddr_o,
	output logic                      arvalid_o,
	input  wire logic                 arready_i,
	input  wire logic [31:0]          rdata_i,
	input  wire mims_pkg::mims_resp_t rresp_i,
	input  wire logic                 rvalid_i,
	output logic                      rready_o
);
	initial begin
		{awaddr_o, wdata_o, araddr_o} = '0;
		{awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
		wstrb_o = 4'hF;
	end

	// handshakes are judged at the negedge so the edge itself carries no race
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		tb = 1'b0;
		r = 2'h3;
		@(posedge clk_i);
		awaddr_o <= a;
		wdata_o <= d;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		while (!tb) begin
			@(negedge clk_i);
			ta = awvalid_o && awready_i;
			tw = wvalid_o && wready_i;
			tb = bvalid_i && bready_o;
			if (tb) r = bresp_i;
			@(posedge clk_i);
			if (ta) awvalid_o <= 1'b0;
			if (tw) wvalid_o <= 1'b0;
			if (tb) bready_o <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tb;
		tb = 1'b0;
		r = 2'h3;
		d = '0;
		@(posedge clk_i);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		while (!tb) begin
			@(negedge clk_i);
			ta = arvalid_o && arready_i;
			tb = rvalid_i && rready_o;
			if (tb) {d, r} = {rdata_i, rresp_i};
			@(posedge clk_i);
			if (ta) arvalid_o <= 1'b0;
			if (tb) rready_o <= 1'b0;
		end
	endtask : rd
endmodule : mims_host

// [tb_matrix_int_mul_sub_long_long.sv]
/* Self-checking bench: register map, refusals, multiply-subtract and outer product.
   Assumes VL of 128, hence 16 array vectors of 4 words. */
`timescale 1ns/1ps
module tb_matrix_int_mul_sub_long_long;
	import mims_pkg::*;
	localparam int VL = 128;
	logic clk_i, rst_n_i;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	mims_resp_t bresp, rresp;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [1:0] rsp;
	logic [31:0] d;
	logic [127:0] z [32];
	logic [127:0] ma [16];
	logic [15:0] p [8];
	logic [31:0] w [4] = '{32'h7, 32'h2, 32'hD, 32'h1};

	mims_top #(.VL(VL)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready));
	mims_host u_host (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
		.awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
		.wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
		.araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
		.rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// generous ceiling: the whole sequence needs well under ten thousand cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [31:0] pat(int k, int i);
		return 32'h9E3779B9 * (k * 4 + i + 1);
	endfunction : pat

	function automatic logic [31:0] mk(int op, es, four, multi, vr, ofs, sa, sb, da, ga, gb);
		return 32'(op << 1 | es << 2 | four << 3 | multi << 4 | vr << 5 | ofs << 7 |
			sa << 8 | sb << 13 | da << 18 | ga << 20 | gb << 23);
	endfunction : mk

	task automatic put(input int sp, input int e, input int k, input logic [31:0] v);
		u_host.wr(32'hC, 32'(sp | e << 4 | k << 12), rsp);
		u_host.wr(32'h10, v, rsp);
	endtask : put

	task automatic get(input int sp, input int e, input int k, output logic [31:0] v);
		u_host.wr(32'hC, 32'(sp | e << 4 | k << 12), rsp);
		u_host.rd(32'h10, v, rsp);
	endtask : get

	task automatic run(input logic [31:0] c, input logic [31:0] st);
		int n;
		n = 0;
		u_host.wr(32'h0, c | 32'h1, rsp);
		d = 32'h1;
		while (d[0] && n < 60) begin
			u_host.rd(32'h8, d, rsp);
			n++;
		end
		chk(d, st);
	endtask : run

	task automatic go(input logic [31:0] cfg, input logic [31:0] c, input logic [31:0] st);
		u_host.wr(32'h4, cfg, rsp);
		run(c, st);
	endtask : go

	task automatic cmp_arr;
		logic [31:0] v;
		for (int a = 0; a < 16; a++)
			for (int k = 0; k < 4; k++) begin
				get(3, a, k, v);
				chk(v, ma[a][k*32+:32]);
			end
	endtask : cmp_arr

	task automatic do_ms(input int four, multi, es, vr, ofs, sa, sb);
		int nr, n, m, vec, ne;
		logic [127:0] a, b;
		longint x, y, pr;
		nr = four ? 4 : 2;
		n = multi ? sa * nr : sa;
		m = multi ? sb * nr : sb;
		vec = (int'(w[vr]) + ofs * 4) % (16 / nr);
		vec = vec - vec % 4;
		ne = es ? 2 : 4;
		for (int r = 0; r < nr; r++) begin
			a = z[(n + r) % 32];
			b = z[multi ? m + r : m];
			for (int i = 0; i < 4; i++)
				for (int e = 0; e < ne; e++) begin
					x = es ? longint'($signed(a[(4*e+i)*16+:16])) : longint'($signed(a[(4*e+i)*8+:8]));
					y = es ? longint'($signed(b[(4*e+i)*16+:16])) : longint'($signed(b[(4*e+i)*8+:8]));
					pr = x * y;
					if (es) ma[vec+i][e*64+:64] -= pr;
					else ma[vec+i][e*32+:32] -= pr[31:0];
				end
			vec += 16 / nr;
		end
		run(mk(0, es, four, multi, vr, ofs, sa, sb, 0, 0, 0), 32'h2);
		cmp_arr();
	endtask : do_ms

	task automatic do_op(input int da, ga, gb, sa, sb);
		logic [31:0] s;
		for (int row = 0; row < 4; row++)
			for (int col = 0; col < 4; col++) begin
				s = ma[4*row+da][col*32+:32];
				for (int k = 0; k < 2; k++)
					if (p[ga][2*(2*row+k)] && p[gb][2*(2*col+k)])
						s += int'($signed(z[sa][(2*row+k)*16+:16])) * int'($signed(z[sb][(2*col+k)*16+:16]));
				ma[4*row+da][col*32+:32] = s;
			end
		run(mk(1, 0, 0, 0, 0, 0, sa, sb, da, ga, gb), 32'h2);
		cmp_arr();
	endtask : do_op

	initial begin
		rst_n_i = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		u_host.rd(32'h4, d, rsp);
		chk(d, 32'hF);
		u_host.rd(32'h8, d, rsp);
		chk(d, 32'h0);
		u_host.rd(32'h0, d, rsp);
		chk(d, 32'h0);
		$display("test reset done");
		u_host.wr(32'h100, 32'h0, rsp);
		chk({30'h0, rsp}, 32'h2);
		u_host.rd(32'h14, d, rsp);
		chk({30'h0, rsp}, 32'h2);
		$display("test unmapped done");
		for (int k = 0; k < 32; k++)
			for (int i = 0; i < 4; i++) begin
				z[k][i*32+:32] = pat(k, i);
				put(0, k, i, pat(k, i));
				if (k < 16) ma[k][i*32+:32] = pat(k + 40, i);
				if (k < 16) put(3, k, i, pat(k + 40, i));
			end
		p[3] = 16'hDF7B;
		p[6] = 16'hF5BF;
		put(1, 3, 0, {16'h0, p[3]});
		put(1, 6, 0, {16'h0, p[6]});
		for (int j = 0; j < 4; j++)
			put(2, j, 0, w[j]);
		go(32'hE, mk(0, 0, 0, 1, 1, 1, 3, 5, 0, 0, 0), 32'h6);
		go(32'hE, mk(1, 0, 0, 0, 0, 0, 1, 2, 1, 3, 6), 32'h6);
		go(32'hD, mk(0, 1, 1, 0, 2, 0, 4, 4, 0, 0, 0), 32'h6);
		go(32'hB, mk(1, 0, 0, 0, 0, 0, 1, 2, 1, 3, 6), 32'hA);
		go(32'h7, mk(0, 0, 0, 1, 1, 1, 3, 5, 0, 0, 0), 32'hA);
		u_host.wr(32'h4, 32'hF, rsp);
		$display("test refusal done");
		do_ms(0, 1, 0, 1, 1, 3, 5);
		do_ms(1, 0, 1, 2, 0, 30, 9);
		do_ms(1, 1, 1, 3, 1, 7, 2);
		$display("test multiply-subtract done");
		do_op(2, 3, 6, 17, 22);
		$display("test outer product done");
		summarize();
	end
endmodule : tb_matrix_int_mul_sub_long_long
